// File: rpo_pkg.sv
`default_nettype none
package rpo_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam int NUM_CHAN = 3;
	localparam int NUM_PORTS = NUM_CHAN + 1;
	localparam int HOP_PORT = 0;
	localparam int FIFO_DEPTH_DEF = 8;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [2:0] BIT_CNT_ONE = 3'h1;

	// ------------------------------------------------------------
	// Timing: bit clock on the link, sampled by clk
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_CLK_RATIO = LINK_PERIOD_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic first_of_frame;
		logic [BYTE_BITS-1:0] oh_byte;
	} rpo_byte_t;

	localparam int BYTE_W = $bits(rpo_byte_t);
endpackage // rpo_pkg
`default_nettype wire

// File: rpo_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
		$error("rpo_fifo: DEPTH must be at least 2 and WIDTH at least 1");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic in_ready_ff;
	logic out_valid_ff;

	wire logic do_push = in_valid && in_ready_ff;
	wire logic do_pop = out_ready && out_valid_ff;
	wire logic [AW:0] nxt_count = count_ff + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
	wire logic [AW-1:0] nxt_wr_ptr = (wr_ptr_ff == LAST_IDX) ? '0 : wr_ptr_ff + AW'(1);
	wire logic [AW-1:0] nxt_rd_ptr = (rd_ptr_ff == LAST_IDX) ? '0 : rd_ptr_ff + AW'(1);

	assign in_ready = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// Flags registered from next count, so full and empty are exact
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready_ff <= 1'h0;
			out_valid_ff <= 1'h0;
		end else begin
			wr_ptr_ff <= do_push ? nxt_wr_ptr : wr_ptr_ff;
			rd_ptr_ff <= do_pop ? nxt_rd_ptr : rd_ptr_ff;
			count_ff <= nxt_count;
			in_ready_ff <= nxt_count != DEPTH_CNT;
			out_valid_ff <= nxt_count != '0;
		end
	end
endmodule // rpo_fifo
`default_nettype wire

// File: rpo_rx_overhead_ports.sv
// Summary of operation
// R1: Port outputs change only on clock fall.
// R2: Capture logic samples on output clock rise.
// R3: Dedicated high-order port with four signals.
// R4: High-order outputs updated on its clock fall.
// R5: One serial port per STS-1 channel.
// R6: Frame pulse high during J1, else low.
// R7: Valid high exactly while data bits shown.
// R8: Loss-of-frame flag follows declared defect.
// R9: Severe-errored-frame flag follows declared defect.
// R10: Loss-of-signal flag follows declared defect.
// R11: High-order data carries received overhead bytes.
// R12: Bytes shifted MSB first, J1 leading.
`timescale 1ns/10ps
`default_nettype none
module rpo_rx_overhead_ports #(
	parameter int FIFO_DEPTH = rpo_pkg::FIFO_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic link_bit_clock,
	input wire rpo_pkg::rpo_byte_t hop_poh_in,
	input wire logic hop_poh_in_valid,
	output logic hop_poh_in_ready,
	input wire rpo_pkg::rpo_byte_t [rpo_pkg::NUM_CHAN-1:0] chan_poh_in,
	input wire logic [rpo_pkg::NUM_CHAN-1:0] chan_poh_in_valid,
	output logic [rpo_pkg::NUM_CHAN-1:0] chan_poh_in_ready,
	input wire logic frame_loss_in,
	input wire logic severe_errored_frame_in,
	input wire logic signal_loss_in,
	output logic hop_overhead_out_clock,
	output logic hop_overhead_serial_data,
	output logic hop_overhead_frame_pulse,
	output logic hop_overhead_valid_strobe,
	output logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_out_clock,
	output logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_serial_data,
	output logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_frame_pulse,
	output logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_valid_strobe,
	output logic frame_loss_flag,
	output logic severe_errored_frame_flag,
	output logic signal_loss_flag
);
	localparam int NP = rpo_pkg::NUM_PORTS;
	localparam int BW = rpo_pkg::BYTE_BITS;

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// Three-bit counter serves bytes of eight bits only
	if (int'(rpo_pkg::LAST_BIT_IDX) != BW - 1) begin : g_bad_width
		$error("rpo_rx_overhead_ports: bit counter does not match byte width");
	end
	// Output slicing assumes the high-order port in slot 0
	if (rpo_pkg::HOP_PORT != 0 || NP != rpo_pkg::NUM_CHAN + 1) begin : g_bad_map
		$error("rpo_rx_overhead_ports: high-order port must sit in slot 0");
	end
	// Fewer than two words leaves no room to refill while shifting
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("rpo_rx_overhead_ports: FIFO_DEPTH must be at least 2");
	end

	// ------------------------------------------------------------
	// Link bit clock sampling
	// ------------------------------------------------------------
	// Stage one only feeds stage two; a change counts once two and three agree
	// Trade-off: three flops cost up to four clk of lag per edge
	logic link_s1_ff;
	logic link_s2_ff;
	logic link_s3_ff;
	logic link_level_ff;

	wire logic link_stable = link_s2_ff == link_s3_ff;
	wire logic link_fall = link_stable && link_level_ff && !link_s3_ff;
	wire logic link_rise = link_stable && !link_level_ff && link_s3_ff;
	// Level only moves once two stages agree, so a one-clk glitch makes no edge
	wire logic nxt_link_level = link_stable ? link_s3_ff : link_level_ff;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			link_s1_ff <= 1'h0;
			link_s2_ff <= 1'h0;
			link_s3_ff <= 1'h0;
			link_level_ff <= 1'h0;
		end else begin
			link_s1_ff <= link_bit_clock;
			link_s2_ff <= link_s1_ff;
			link_s3_ff <= link_s2_ff;
			link_level_ff <= nxt_link_level;
		end
	end

	// ------------------------------------------------------------
	// Per-port input gathering, index 0 is the high-order port
	// ------------------------------------------------------------
	rpo_pkg::rpo_byte_t [NP-1:0] port_in;
	logic [NP-1:0] port_in_valid;
	logic [NP-1:0] port_in_ready;
	logic [NP-1:0] out_clock_ff;
	logic [NP-1:0] serial_ff;
	logic [NP-1:0] frame_ff;
	logic [NP-1:0] valid_ff;

	assign port_in = {chan_poh_in, hop_poh_in};
	assign port_in_valid = {chan_poh_in_valid, hop_poh_in_valid};
	assign hop_poh_in_ready = port_in_ready[rpo_pkg::HOP_PORT];
	assign chan_poh_in_ready = port_in_ready[NP-1:1];

	// ------------------------------------------------------------
	// Serial ports
	// ------------------------------------------------------------
	// R3: high-order port is slot 0
	// R5: one slot per channel
	for (genvar p = 0; p < NP; p++) begin : g_port
		rpo_pkg::rpo_byte_t fifo_data;
		logic fifo_valid;
		logic [BW-1:0] shift_ff;
		logic [2:0] bits_left_ff;

		// Byte still in flight keeps priority over a fresh load
		wire logic mid_byte = valid_ff[p] && (bits_left_ff != rpo_pkg::BIT_CNT_ZERO);
		wire logic load_byte = link_fall && !mid_byte && fifo_valid;

		// Eight-word buffer absorbs bursts from the overhead processor
		rpo_fifo #(
			.WIDTH(rpo_pkg::BYTE_W),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.clk(clk),
			.reset_n(reset_n),
			.in_data(port_in[p]),
			.in_valid(port_in_valid[p]),
			.in_ready(port_in_ready[p]),
			.out_data(fifo_data),
			.out_valid(fifo_valid),
			.out_ready(load_byte)
		);

		// Output clock mirrors the sampled link level
		// Own copy per port, though all follow one link clock
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				out_clock_ff[p] <= 1'h0;
			end else if (link_fall || link_rise) begin
				out_clock_ff[p] <= link_rise;
			end
		end

		// R11: fifo bytes become serial bits
		// R12: MSB leads, then next lower bit
		wire logic [BW-1:0] src_byte = mid_byte ? shift_ff : fifo_data.oh_byte;
		wire logic [BW-1:0] nxt_shift = {src_byte[BW-2:0], 1'h0};
		// Idle bit periods show zero data
		wire logic nxt_serial = (mid_byte || fifo_valid) && src_byte[BW-1];
		wire logic [2:0] bits_after = bits_left_ff - rpo_pkg::BIT_CNT_ONE;
		wire logic [2:0] bits_fresh = fifo_valid ? rpo_pkg::LAST_BIT_IDX : rpo_pkg::BIT_CNT_ZERO;
		wire logic [2:0] nxt_bits_left = mid_byte ? bits_after : bits_fresh;
		// R6: high for the whole J1 byte
		wire logic nxt_frame = mid_byte ? frame_ff[p] : fifo_valid && fifo_data.first_of_frame;
		// R7: valid exactly while bits shown
		wire logic nxt_valid = mid_byte || fifo_valid;

		// R1: updates only with the clock fall
		// R4: same timing on high-order port
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				shift_ff <= '0;
				bits_left_ff <= rpo_pkg::BIT_CNT_ZERO;
				serial_ff[p] <= 1'h0;
				frame_ff[p] <= 1'h0;
				valid_ff[p] <= 1'h0;
			end else if (link_fall) begin
				shift_ff <= nxt_shift;
				bits_left_ff <= nxt_bits_left;
				serial_ff[p] <= nxt_serial;
				frame_ff[p] <= nxt_frame;
				valid_ff[p] <= nxt_valid;
			end
		end
	end

	// ------------------------------------------------------------
	// Output pins
	// ------------------------------------------------------------
	// R2: capture on rise is safe
	assign hop_overhead_out_clock = out_clock_ff[rpo_pkg::HOP_PORT];
	assign hop_overhead_serial_data = serial_ff[rpo_pkg::HOP_PORT];
	assign hop_overhead_frame_pulse = frame_ff[rpo_pkg::HOP_PORT];
	assign hop_overhead_valid_strobe = valid_ff[rpo_pkg::HOP_PORT];
	assign chan_overhead_out_clock = out_clock_ff[NP-1:1];
	assign chan_overhead_serial_data = serial_ff[NP-1:1];
	assign chan_overhead_frame_pulse = frame_ff[NP-1:1];
	assign chan_overhead_valid_strobe = valid_ff[NP-1:1];

	// ------------------------------------------------------------
	// Defect indicators
	// ------------------------------------------------------------
	// Defects come from logic on clk, so no synchroniser
	logic frame_loss_ff;
	logic severe_ff;
	logic signal_loss_ff;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frame_loss_ff <= 1'h0;
			severe_ff <= 1'h0;
			signal_loss_ff <= 1'h0;
		end else begin
			// R8: follow loss of frame
			frame_loss_ff <= frame_loss_in;
			// R9: follow severely errored frame
			severe_ff <= severe_errored_frame_in;
			// R10: follow loss of signal
			signal_loss_ff <= signal_loss_in;
		end
	end

	assign frame_loss_flag = frame_loss_ff;
	assign severe_errored_frame_flag = severe_ff;
	assign signal_loss_flag = signal_loss_ff;
endmodule // rpo_rx_overhead_ports
`default_nettype wire

// File: rpo_cap.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_cap (
	input wire logic out_clock,
	input wire logic serial_data,
	input wire logic frame_pulse,
	input wire logic valid_strobe
);
	// ------
	// Capture
	// ------
	logic [7:0] shift_ff = 8'h0;
	logic frame_ff = 1'h0;
	int bit_cnt = 0;
	int n = 0;
	int split = 0;
	logic [8:0] got [16];
	always @(posedge out_clock) begin
		if (valid_strobe) begin
			if (bit_cnt == 0) frame_ff = frame_pulse;
			if (bit_cnt > 0 && frame_pulse !== frame_ff) split++;
			shift_ff = {shift_ff[6:0], serial_data};
			bit_cnt++;
			if (bit_cnt == 8) begin
				got[n % 16] = {frame_ff, shift_ff};
				n++;
				bit_cnt = 0;
			end
		end
	end
endmodule // rpo_cap
`default_nettype wire

// File: rpo_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic frame_loss_in,
	input wire logic severe_errored_frame_in,
	input wire logic signal_loss_in,
	input wire logic hop_overhead_out_clock,
	input wire logic hop_overhead_serial_data,
	input wire logic hop_overhead_frame_pulse,
	input wire logic hop_overhead_valid_strobe,
	input wire logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_out_clock,
	input wire logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_serial_data,
	input wire logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_frame_pulse,
	input wire logic [rpo_pkg::NUM_CHAN-1:0] chan_overhead_valid_strobe,
	input wire logic frame_loss_flag,
	input wire logic severe_errored_frame_flag,
	input wire logic signal_loss_flag
);
	// ------
	// Port rules
	// ------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_hop_fall_upd: assert property (
		$changed({hop_overhead_serial_data, hop_overhead_frame_pulse, hop_overhead_valid_strobe})
		|-> $fell(hop_overhead_out_clock)) else $error("hop output moved off clock fall");
	a_chan_fall_upd: assert property (
		$changed({chan_overhead_serial_data, chan_overhead_frame_pulse, chan_overhead_valid_strobe})
		|-> chan_overhead_out_clock == '0 && $past(chan_overhead_out_clock) == '1)
		else $error("chan output moved off clock fall");
	a_hop_frame_valid: assert property (hop_overhead_frame_pulse |-> hop_overhead_valid_strobe)
		else $error("hop frame pulse without valid");
	a_chan_frame_valid: assert property ((chan_overhead_frame_pulse & ~chan_overhead_valid_strobe) == '0)
		else $error("chan frame pulse without valid");
	a_hop_idle_data: assert property (!hop_overhead_valid_strobe |-> !hop_overhead_serial_data)
		else $error("hop data active while not valid");
	a_chan_idle_data: assert property ((chan_overhead_serial_data & ~chan_overhead_valid_strobe) == '0)
		else $error("chan data active while not valid");
	a_lof_follow: assert property ($past(reset_n) |-> frame_loss_flag == $past(frame_loss_in))
		else $error("frame loss flag wrong");
	a_sef_follow: assert property ($past(reset_n) |-> severe_errored_frame_flag == $past(severe_errored_frame_in))
		else $error("severe errored frame flag wrong");
	a_los_follow: assert property ($past(reset_n) |-> signal_loss_flag == $past(signal_loss_in))
		else $error("signal loss flag wrong");
endmodule // rpo_chk
bind rpo_rx_overhead_ports rpo_chk chk_u (.*);
`default_nettype wire

// File: rx_path_overhead_serial_ports_test.sv
`timescale 1ns/10ps
`default_nettype none
module rx_path_overhead_serial_ports_test;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic link_clk = 1'h0;
	rpo_pkg::rpo_byte_t hop_in = '0;
	logic hop_v = 1'h0;
	logic hop_rdy;
	rpo_pkg::rpo_byte_t [2:0] ch_in = '0;
	logic [2:0] ch_v = 3'h0;
	logic [2:0] ch_rdy;
	logic [2:0] def_in = 3'h0;
	logic [2:0] def_out;
	logic hck, hd, hf, hv;
	logic [2:0] cck, cd, cf, cv;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int k;
	logic full_seen = 1'h0;
	logic [8:0] rows [10] = '{9'h1a5, 9'h080, 9'h001, 9'h0ff, 9'h05a, 9'h1c3, 9'h07e, 9'h000, 9'h0e1, 9'h033};
	// ------
	// Setup
	// ------
	always #10 clk = ~clk;
	initial begin
		#7;
		forever #80 link_clk = ~link_clk;
	end
	rpo_rx_overhead_ports dut_u (.clk(clk), .reset_n(reset_n), .link_bit_clock(link_clk), .hop_poh_in(hop_in),
		.hop_poh_in_valid(hop_v), .hop_poh_in_ready(hop_rdy), .chan_poh_in(ch_in), .chan_poh_in_valid(ch_v),
		.chan_poh_in_ready(ch_rdy), .frame_loss_in(def_in[2]), .severe_errored_frame_in(def_in[1]),
		.signal_loss_in(def_in[0]), .hop_overhead_out_clock(hck), .hop_overhead_serial_data(hd),
		.hop_overhead_frame_pulse(hf), .hop_overhead_valid_strobe(hv), .chan_overhead_out_clock(cck),
		.chan_overhead_serial_data(cd), .chan_overhead_frame_pulse(cf), .chan_overhead_valid_strobe(cv),
		.frame_loss_flag(def_out[2]), .severe_errored_frame_flag(def_out[1]), .signal_loss_flag(def_out[0]));
	rpo_cap cap_h (.out_clock(hck), .serial_data(hd), .frame_pulse(hf), .valid_strobe(hv));
	rpo_cap cap_0 (.out_clock(cck[0]), .serial_data(cd[0]), .frame_pulse(cf[0]), .valid_strobe(cv[0]));
	rpo_cap cap_1 (.out_clock(cck[1]), .serial_data(cd[1]), .frame_pulse(cf[1]), .valid_strobe(cv[1]));
	rpo_cap cap_2 (.out_clock(cck[2]), .serial_data(cd[2]), .frame_pulse(cf[2]), .valid_strobe(cv[2]));
	function automatic logic [8:0] exp_w(input int r, input int p);
		return {rows[r][8], rows[r][7:0] + 8'(p)};
	endfunction
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Valid stays up across pushes, so back-to-back words need no gap
	task automatic push(input int r);
		int w;
		w = 0;
		hop_in = rows[r];
		for (int p = 0; p < 3; p++) ch_in[p] = exp_w(r, p + 1);
		hop_v = 1'h1;
		ch_v = 3'h7;
		while (!(hop_rdy && ch_rdy == 3'h7) && w < 500) begin
			full_seen = 1'h1;
			w++;
			@(negedge clk);
		end
		@(negedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end
	// ------
	// Main sequence
	// ------
	initial begin
		repeat (5) @(negedge clk);
		reset_n = 1'h1;
		repeat (3) @(negedge clk);
		for (k = 0; k < 10; k++) push(k);
		hop_v = 1'h0;
		ch_v = 3'h0;
		check("fifo_refused", {8'h0, full_seen}, 9'h1);
		while (cap_h.n < 10 || cap_0.n < 10 || cap_1.n < 10 || cap_2.n < 10) @(negedge clk);
		for (k = 0; k < 10; k++) begin
			check("hop_byte", cap_h.got[k], rows[k]);
			check("chan0_byte", cap_0.got[k], exp_w(k, 1));
			check("chan1_byte", cap_1.got[k], exp_w(k, 2));
			check("chan2_byte", cap_2.got[k], exp_w(k, 3));
		end
		check("frame_split", 9'(cap_h.split + cap_0.split + cap_1.split + cap_2.split), 9'h0);
		for (k = 0; k < 8; k++) begin
			def_in = 3'(k);
			@(negedge clk);
			check("defect_flags", {6'h0, def_out}, {6'h0, def_in});
		end
		hop_v = 1'h1;
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		check("reset_outputs", {hop_rdy, ch_rdy, def_out, hv, hf}, 9'h0);
		hop_v = 1'h0;
		end_of_test();
	end
endmodule // rx_path_overhead_serial_ports_test
`default_nettype wire
